// file: core/dcu_device.sv
`timescale 1ns/100ps
`include "dcu_cfg.svh"
module dcu_device #(
  parameter int unsigned GAP_CYC = `DCU_INIT_GAP_CYC,
  parameter int unsigned TMO_CYC = `DCU_INIT_TMO_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  dcu_link_if.device LINK,
  input wire logic CHAIN_I,
  output wire logic CHAIN_O,
  output wire logic CHAIN_OE,
  input wire dcu_pkg::dcu_addr_type NV_ADDR,
  input wire logic NV_VALID,
  output logic NV_WR,
  output dcu_pkg::dcu_addr_type MY_ADDR,
  output logic REG_WR,
  output dcu_pkg::dcu_byte_type REG_PTR,
  output dcu_pkg::dcu_word_type REG_WDATA,
  input wire dcu_pkg::dcu_word_type REG_RDATA,
  output logic SOFT_RESET,
  output logic ALERT_CLEAR_1,
  output logic ALERT_CLEAR_2
);
  import dcu_pkg::*;

  dcu_dev_state_type st;
  logic [1:0] s1, s2, s3, lvl;
  logic host_d, chain_d;
  logic [15:0] period;
  logic [18:0] cal_cnt;
  logic [2:0] falls;
  logic [7:0] cmd, lo;
  logic nv_loaded;
  logic rx_busy, rx_done;
  logic [15:0] rx_tmr;
  logic [3:0] rx_cnt;
  logic [7:0] rx_sh;
  logic tx_busy;
  logic [9:0] tx_sh;
  logic [3:0] tx_n;
  logic [15:0] tx_tmr;
  logic [23:0] snd_buf;
  logic [1:0] snd_cnt;
  logic [5:0] relay_left;
  logic own_after, is_poll, in_init, got_byte;
  logic [31:0] tmr, init_tmr;

  // Decode of link state and command byte
  wire logic host_fall = host_d & ~lvl[0];
  wire logic rx_src = (st == D_RELAY) ? lvl[1] : lvl[0];
  wire logic rx_src_d = (st == D_RELAY) ? chain_d : host_d;
  wire logic rx_en = (st == D_CMD) || (st == D_PTR) || (st == D_DATA) || (st == D_ADDRW) || (st == D_RELAY);
  // Own answers wait one bit period so the host's last stop bit has ended
  wire logic send_ok = (st == D_SEND) && (tmr >= 32'(period));
  wire logic tx_go = (send_ok || (st == D_INIT_TX)) && !tx_busy && (snd_cnt != 2'h0);
  wire logic [18:0] cal_span = cal_cnt + 19'(`DCU_CAL_ROUND);
  wire logic tx_idle = !tx_busy && (snd_cnt == 2'h0);
  wire logic tx_line = tx_busy ? tx_sh[0] : 1'b1;
  wire logic [4:0] field = cmd[`DCU_FIELD_MSB:`DCU_FIELD_LSB];
  wire logic is_global = cmd[`DCU_GLOBAL_BIT];
  wire logic is_read = cmd[`DCU_RW_BIT];
  wire logic wr_hit = is_global ? (MY_ADDR <= field) : (MY_ADDR == field);
  wire logic [31:0] poll_wait = 32'(period) * 32'(`DCU_POLL_SILENCE_BITS);
  wire logic poll_quiet = is_poll && !got_byte && !rx_busy && (tmr >= poll_wait);
  wire logic init_expired = in_init && (init_tmr >= TMO_CYC - 1);
  wire logic [5:0] relay_span = 6'({1'b0, field} - {1'b0, MY_ADDR}) << 1;

  // Pin drive: own answer, relay upstream, or forward downstream
  assign LINK.dev_o = (st == D_SEND) ? tx_line : lvl[1];
  assign LINK.dev_oe = (st == D_SEND) || (st == D_RELAY);
  assign CHAIN_O = (st == D_INIT_TX) ? tx_line : ((st == D_SEND) ? 1'b1 : lvl[0]);
  assign CHAIN_OE = (st != D_RELAY);

  // Three-stage pin synchronisers, change taken when stages agree
  always_ff @(posedge CLK) begin
    if (RST) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
      lvl <= 2'h3;
      host_d <= 1'b1;
      chain_d <= 1'b1;
    end else begin
      s1 <= {CHAIN_I, LINK.line};
      s2 <= s1;
      s3 <= s2;
      lvl <= (~(s2 ^ s3) & s2) | ((s2 ^ s3) & lvl);
      host_d <= lvl[0];
      chain_d <= lvl[1];
    end
  end

  // Word receiver, mid-bit sampling at measured period
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_tmr <= 16'h0000;
      rx_cnt <= 4'h0;
      rx_sh <= 8'h00;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (rx_en && rx_src_d && !rx_src) begin
          rx_busy <= 1'b1;
          rx_tmr <= period >> 1;
          rx_cnt <= 4'h0;
        end
      end else if (rx_tmr == 16'h0000) begin
        rx_tmr <= period - 16'h0001;
        rx_cnt <= rx_cnt + 4'h1;
        if (rx_cnt != 4'h0 && rx_cnt != 4'h9) begin
          rx_sh <= {rx_src, rx_sh[7:1]};
        end
        if (rx_cnt == 4'h9) begin
          rx_busy <= 1'b0;
          rx_done <= 1'b1;
        end
      end else begin
        rx_tmr <= rx_tmr - 16'h0001;
      end
    end
  end

  // Word transmitter: start, eight data LSB first, stop
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_busy <= 1'b0;
      tx_sh <= 10'h3FF;
      tx_n <= 4'h0;
      tx_tmr <= 16'h0000;
    end else if (tx_go) begin
      tx_sh <= {1'b1, snd_buf[7:0], 1'b0};
      tx_n <= 4'h0;
      tx_busy <= 1'b1;
      tx_tmr <= period - 16'h0001;
    end else if (tx_busy) begin
      if (tx_tmr != 16'h0000) begin
        tx_tmr <= tx_tmr - 16'h0001;
      end else if (tx_n == 4'(`DCU_WORD_BITS - 1)) begin
        tx_busy <= 1'b0;
      end else begin
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_n <= tx_n + 4'h1;
        tx_tmr <= period - 16'h0001;
      end
    end
  end

  // Operation sequencer
  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= D_IDLE;
      period <= 16'hFFFF;
      cal_cnt <= 19'h00000;
      falls <= 3'h0;
      cmd <= 8'h00;
      lo <= 8'h00;
      nv_loaded <= 1'b0;
      MY_ADDR <= `DCU_DEFAULT_ADDR;
      NV_WR <= 1'b0;
      REG_WR <= 1'b0;
      REG_PTR <= 8'h00;
      REG_WDATA <= 16'h0000;
      SOFT_RESET <= 1'b0;
      ALERT_CLEAR_1 <= 1'b0;
      ALERT_CLEAR_2 <= 1'b0;
      snd_buf <= 24'h000000;
      snd_cnt <= 2'h0;
      relay_left <= 6'h00;
      own_after <= 1'b0;
      is_poll <= 1'b0;
      in_init <= 1'b0;
      got_byte <= 1'b0;
      tmr <= 32'h00000000;
      init_tmr <= 32'h00000000;
    end else begin
      NV_WR <= 1'b0;
      REG_WR <= 1'b0;
      SOFT_RESET <= 1'b0;
      ALERT_CLEAR_1 <= 1'b0;
      ALERT_CLEAR_2 <= 1'b0;
      tmr <= tmr + 32'h00000001;
      init_tmr <= in_init ? init_tmr + 32'h00000001 : 32'h00000000;
      if (!nv_loaded) begin
        nv_loaded <= 1'b1;
        if (NV_VALID) begin
          MY_ADDR <= NV_ADDR;
        end
      end
      if (tx_go) begin
        snd_buf <= {8'h00, snd_buf[23:8]};
        snd_cnt <= snd_cnt - 2'h1;
      end
      if (init_expired) begin
        in_init <= 1'b0;
        st <= D_IDLE;
      end else begin
        case (st)
          D_IDLE: begin
            if (host_fall) begin
              cal_cnt <= 19'h00000;
              falls <= 3'h1;
              st <= D_CAL;
            end
          end
          D_CAL: begin
            cal_cnt <= cal_cnt + 19'h00001;
            if (&cal_cnt) begin
              st <= D_IDLE;
            end else if (host_fall) begin
              falls <= falls + 3'h1;
              if (falls == 3'(`DCU_CAL_FALLS - 1)) begin
                period <= cal_span[18:`DCU_CAL_SHIFT];
                st <= D_CMD;
              end
            end
          end
          D_CMD: begin
            if (rx_done) begin
              cmd <= rx_sh;
              tmr <= 32'h00000000;
              if (rx_sh[`DCU_CMD_BIT]) begin
                if (rx_sh == `DCU_CMD_INIT) begin
                  st <= D_ADDRW;
                end else if (rx_sh == `DCU_CMD_POLL) begin
                  is_poll <= 1'b1;
                  own_after <= 1'b0;
                  got_byte <= 1'b0;
                  relay_left <= 6'h01;
                  st <= D_RELAY;
                end else begin
                  SOFT_RESET <= (rx_sh == `DCU_CMD_SRST);
                  ALERT_CLEAR_1 <= (rx_sh == `DCU_CMD_ACLR1);
                  ALERT_CLEAR_2 <= (rx_sh == `DCU_CMD_ACLR2);
                  st <= D_IDLE;
                end
              end else begin
                st <= D_PTR;
              end
            end
          end
          D_PTR: begin
            if (rx_done) begin
              REG_PTR <= rx_sh;
              got_byte <= 1'b0;
              st <= is_read ? D_RDSEL : D_DATA;
            end
          end
          D_RDSEL: begin
            is_poll <= 1'b0;
            got_byte <= 1'b0;
            tmr <= 32'h00000000;
            if (field == MY_ADDR) begin
              snd_buf <= {8'h00, REG_RDATA};
              snd_cnt <= 2'h2;
              st <= D_SEND;
            end else if (field > MY_ADDR) begin
              relay_left <= is_global ? relay_span : 6'h02;
              own_after <= is_global;
              st <= D_RELAY;
            end else begin
              st <= D_IDLE;
            end
          end
          D_DATA: begin
            if (rx_done) begin
              got_byte <= 1'b1;
              lo <= rx_sh;
              if (got_byte) begin
                REG_WR <= wr_hit;
                REG_WDATA <= {rx_sh, lo};
                st <= D_IDLE;
              end
            end
          end
          D_ADDRW: begin
            if (rx_done) begin
              MY_ADDR <= rx_sh[`DCU_FIELD_MSB:`DCU_FIELD_LSB];
              lo <= rx_sh;
              NV_WR <= 1'b1;
              tmr <= 32'h00000000;
              in_init <= 1'b1;
              snd_buf <= {16'h0000, rx_sh};
              snd_cnt <= 2'h1;
              st <= D_SEND;
            end
          end
          D_SEND: begin
            if (tx_idle) begin
              tmr <= 32'h00000000;
              st <= in_init ? D_GAP : D_IDLE;
            end
          end
          D_GAP: begin
            if (tmr >= GAP_CYC - 1) begin
              snd_buf <= {MY_ADDR + 5'h01, lo[2:0], `DCU_CMD_INIT, `DCU_CAL_BYTE};
              snd_cnt <= 2'h3;
              st <= D_INIT_TX;
            end
          end
          D_INIT_TX: begin
            if (tx_idle) begin
              relay_left <= 6'h00;
              own_after <= 1'b0;
              is_poll <= 1'b0;
              st <= D_RELAY;
            end
          end
          D_RELAY: begin
            if (rx_done) begin
              got_byte <= 1'b1;
            end
            if (rx_done && !in_init && relay_left == 6'h01) begin
              if (own_after) begin
                snd_buf <= {8'h00, REG_RDATA};
                snd_cnt <= 2'h2;
                st <= D_SEND;
              end else begin
                st <= D_IDLE;
              end
            end else if (rx_done && !in_init) begin
              relay_left <= relay_left - 6'h01;
            end else if (poll_quiet) begin
              snd_buf <= {16'h0000, MY_ADDR, cmd[2:0]};
              snd_cnt <= 2'h1;
              st <= D_SEND;
            end
          end
          default: begin
            st <= D_IDLE;
          end
        endcase
      end
    end
  end
endmodule // dcu_device

// file: core/dcu_cfg.svh
// Contract
// - Only the host starts any transfer
// - Unaddressed sensors pass host traffic down chain
// - No sensor-to-sensor traffic except address initialization
// - Four modes: idle, answer, forward, relay back
// - Host opens with low start then 55h
// - Baud rate re-measured from every calibration byte
// - Second byte: global, read, command, five-bit field
// - Commands 95, 57, 5D, B5, 75 hex
// - Host sends no undefined command codes
// - Global flag set for commands and multi-device
// - Global field is highest address, else exact
// - Command flag one selects command, zero address
// - Read flag picks register read or write
// - Pointer byte only in address operations
// - Data phase: low byte then high byte
// - Intermediate sensors relay chain answers to host
// - Host sends first address 0 to 31
// - Sensors self-assign incrementing addresses, 7 ms apart
// - Assigned address kept nonvolatile, reloaded at reset
// - Host waits while initialization is running
// - Initialization stall resets link after one second
// - Ten-bit words, LSB first, idle high
// - Uninitialized sensors hold address zero
`ifndef DCU_CFG_SVH
`define DCU_CFG_SVH

// Command and address byte layout
`define DCU_GLOBAL_BIT 0
`define DCU_RW_BIT 1
`define DCU_CMD_BIT 2
`define DCU_FIELD_LSB 3
`define DCU_FIELD_MSB 7

// Byte values
`define DCU_CAL_BYTE 8'h55
`define DCU_CMD_INIT 8'h95
`define DCU_CMD_POLL 8'h57
`define DCU_CMD_SRST 8'h5D
`define DCU_CMD_ACLR1 8'hB5
`define DCU_CMD_ACLR2 8'h75
`define DCU_DEFAULT_ADDR 5'h00

// Framing and calibration
`define DCU_WORD_BITS 10
`define DCU_CAL_FALLS 5
`define DCU_CAL_SHIFT 3
`define DCU_CAL_ROUND 5
`define DCU_POLL_SILENCE_BITS 24

// Timing
`define DCU_CLK_MHZ 125
`define DCU_INIT_GAP_US 7000
`define DCU_INIT_GAP_CYC (`DCU_INIT_GAP_US * `DCU_CLK_MHZ)
`define DCU_INIT_TMO_MS 1000
`define DCU_INIT_TMO_CYC (`DCU_INIT_TMO_MS * 1000 * `DCU_CLK_MHZ)
`define DCU_HOST_LISTEN_MS 35
`define DCU_HOST_LISTEN_CYC (`DCU_HOST_LISTEN_MS * 1000 * `DCU_CLK_MHZ)
`define DCU_HOST_BAUD 115200
`define DCU_HOST_BAUD_DIV ((`DCU_CLK_MHZ * 1000000) / `DCU_HOST_BAUD)

`endif

// file: core/dcu_pkg.sv
package dcu_pkg;
  typedef logic [7:0] dcu_byte_type;
  typedef logic [15:0] dcu_word_type;
  typedef logic [4:0] dcu_addr_type;
  typedef enum logic [3:0] {
    D_IDLE = 4'h0,
    D_CAL = 4'h1,
    D_CMD = 4'h3,
    D_PTR = 4'h2,
    D_RDSEL = 4'h6,
    D_SEND = 4'h7,
    D_DATA = 4'h5,
    D_ADDRW = 4'h4,
    D_GAP = 4'hC,
    D_INIT_TX = 4'hD,
    D_RELAY = 4'hF
  } dcu_dev_state_type;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_SEND = 2'h1,
    H_LISTEN = 2'h3
  } dcu_host_state_type;
endpackage

// file: core/dcu_link_if.sv
`timescale 1ns/100ps
interface dcu_link_if;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic line;
  // Pulled-up wire, low wins
  assign line = ~((host_oe & ~host_o) | (dev_oe & ~dev_o));
  modport host (output host_o, output host_oe, input line);
  modport device (output dev_o, output dev_oe, input line);
endinterface

// file: core/dcu_host.sv
`timescale 1ns/100ps
`include "dcu_cfg.svh"
module dcu_host #(
  parameter int unsigned BAUD_DIV = `DCU_HOST_BAUD_DIV,
  parameter int unsigned LISTEN_CYC = `DCU_HOST_LISTEN_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  dcu_link_if.host LINK,
  input wire logic REQ_VALID,
  output wire logic REQ_READY,
  input wire dcu_pkg::dcu_byte_type REQ_CMD,
  input wire dcu_pkg::dcu_byte_type REQ_PTR,
  input wire dcu_pkg::dcu_word_type REQ_DATA,
  output logic RSP_VALID,
  output dcu_pkg::dcu_byte_type RSP_BYTE,
  output logic DONE
);
  import dcu_pkg::*;

  dcu_host_state_type st;
  logic s1, s2, s3, lvl, lvl_d;
  logic [15:0] div_cnt;
  logic [39:0] buf_q;
  logic [2:0] cnt;
  logic listen;
  logic tx_busy;
  logic [9:0] tx_sh;
  logic [3:0] tx_n;
  logic rx_busy;
  logic [15:0] rx_tmr;
  logic [3:0] rx_cnt;
  logic [7:0] rx_sh;
  logic [31:0] sil;

  // Request decode and bit-rate enable
  wire logic tick = (div_cnt == 16'h0000);
  wire logic is_cmd = REQ_CMD[`DCU_CMD_BIT];
  wire logic is_init = (REQ_CMD == `DCU_CMD_INIT);
  wire logic cmd_known = is_init || (REQ_CMD == `DCU_CMD_POLL) || (REQ_CMD == `DCU_CMD_SRST) ||
    (REQ_CMD == `DCU_CMD_ACLR1) || (REQ_CMD == `DCU_CMD_ACLR2);
  wire logic take = REQ_VALID && (st == H_IDLE);
  wire logic [15:0] div_m1 = 16'(BAUD_DIV - 1);
  assign REQ_READY = (st == H_IDLE);
  assign LINK.host_o = tx_sh[0];
  assign LINK.host_oe = tx_busy;

  // Line synchroniser
  always_ff @(posedge CLK) begin
    if (RST) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      lvl <= 1'b1;
      lvl_d <= 1'b1;
    end else begin
      s1 <= LINK.line;
      s2 <= s1;
      s3 <= s2;
      lvl <= (s2 == s3) ? s2 : lvl;
      lvl_d <= lvl;
    end
  end

  // Divider, frame sender and operation sequence
  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= H_IDLE;
      div_cnt <= 16'h0000;
      buf_q <= 40'h0000000000;
      cnt <= 3'h0;
      listen <= 1'b0;
      tx_busy <= 1'b0;
      tx_sh <= 10'h3FF;
      tx_n <= 4'h0;
      DONE <= 1'b0;
    end else begin
      DONE <= 1'b0;
      div_cnt <= tick ? div_m1 : div_cnt - 16'h0001;
      case (st)
        H_IDLE: begin
          if (take && is_cmd && !cmd_known) begin
            DONE <= 1'b1;
          end else if (take) begin
            if (is_cmd) begin
              buf_q <= {16'h0000, REQ_DATA[7:0], REQ_CMD, `DCU_CAL_BYTE};
              cnt <= is_init ? 3'h3 : 3'h2;
              listen <= is_init || (REQ_CMD == `DCU_CMD_POLL);
            end else begin
              buf_q <= {REQ_DATA, REQ_PTR, REQ_CMD, `DCU_CAL_BYTE};
              cnt <= REQ_CMD[`DCU_RW_BIT] ? 3'h3 : 3'h5;
              listen <= REQ_CMD[`DCU_RW_BIT];
            end
            st <= H_SEND;
          end
        end
        H_SEND: begin
          if (tick) begin
            if (!tx_busy && cnt != 3'h0) begin
              tx_sh <= {1'b1, buf_q[7:0], 1'b0};
              buf_q <= {8'h00, buf_q[39:8]};
              cnt <= cnt - 3'h1;
              tx_n <= 4'h0;
              tx_busy <= 1'b1;
            end else if (tx_busy && tx_n == 4'(`DCU_WORD_BITS - 1)) begin
              tx_busy <= 1'b0;
              tx_sh <= 10'h3FF;
              if (cnt == 3'h0 && listen) begin
                st <= H_LISTEN; // Listen from the end of the last stop bit
              end
            end else if (tx_busy) begin
              tx_sh <= {1'b1, tx_sh[9:1]};
              tx_n <= tx_n + 4'h1;
            end else begin
              DONE <= !listen;
              st <= listen ? H_LISTEN : H_IDLE;
            end
          end
        end
        H_LISTEN: begin
          if (!rx_busy && sil >= LISTEN_CYC - 1) begin
            DONE <= 1'b1;
            st <= H_IDLE;
          end
        end
        default: begin
          st <= H_IDLE;
        end
      endcase
    end
  end

  // Answer receiver, aligned to each start bit's falling edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_busy <= 1'b0;
      rx_tmr <= 16'h0000;
      rx_cnt <= 4'h0;
      rx_sh <= 8'h00;
      sil <= 32'h00000000;
      RSP_VALID <= 1'b0;
      RSP_BYTE <= 8'h00;
    end else begin
      RSP_VALID <= 1'b0;
      sil <= (st == H_LISTEN && !rx_busy) ? sil + 32'h00000001 : 32'h00000000;
      if (!rx_busy) begin
        if (st == H_LISTEN && lvl_d && !lvl) begin
          rx_busy <= 1'b1;
          rx_tmr <= div_m1 >> 1;
          rx_cnt <= 4'h0;
        end
      end else if (rx_tmr == 16'h0000) begin
        rx_tmr <= div_m1;
        rx_cnt <= rx_cnt + 4'h1;
        if (rx_cnt != 4'h0) begin
          rx_sh <= {lvl, rx_sh[7:1]};
        end
        if (rx_cnt == 4'h8) begin
          rx_busy <= 1'b0;
          RSP_VALID <= 1'b1;
          RSP_BYTE <= {lvl, rx_sh[7:1]};
        end
      end else begin
        rx_tmr <= rx_tmr - 16'h0001;
      end
    end
  end
endmodule // dcu_host

// file: tb/dcu_link_props.sv
`timescale 1ns/100ps
module dcu_link_props #(
  parameter int unsigned BAUD_DIV = 16
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic line,
  input wire logic CHAIN_I,
  input wire logic CHAIN_O,
  input wire logic CHAIN_OE
);
  int unsigned run;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Cycles the host has driven in the current frame
  always_ff @(posedge CLK) begin
    run <= (RST || !host_oe) ? 0 : run + 1;
  end
  // Host framing on the shared line
  a_host_start_low: assert property ($rose(host_oe) |-> !host_o)
    else $error("host frame without low start");
  a_host_stop_high: assert property ($fell(host_oe) |-> $past(host_o) && $past(host_o, 8))
    else $error("host frame without high stop");
  a_host_frame_len: assert property ($fell(host_oe) |-> run + 2 >= 10 * BAUD_DIV && run <= 10 * BAUD_DIV + 2)
    else $error("host frame length wrong");
  a_no_talk_over: assert property (host_oe && dev_oe |-> host_o)
    else $error("sensor drove over a host bit");
  // Sensor forwarding and relaying
  a_fwd_follow: assert property ($fell(line) && CHAIN_OE && !dev_oe |-> ##[1:6] !CHAIN_O)
    else $error("host edge not forwarded down the chain");
  a_relay_back: assert property ($fell(CHAIN_I) && !CHAIN_OE |-> ##[1:6] !line)
    else $error("chain edge not relayed to host");
  a_relay_drives: assert property (!CHAIN_OE |-> dev_oe)
    else $error("relay mode without host side drive");
  a_dev_oe_hold: assert property ($rose(dev_oe) |-> dev_oe [*8])
    else $error("sensor drive window too short");
  a_dev_end_high: assert property ($fell(dev_oe) |-> $past(dev_o) && $past(dev_o, 2))
    else $error("sensor released line while low");
  // Main scenarios reached
  c_answer: cover property ($rose(dev_oe));
  c_relay: cover property ($fell(CHAIN_OE));
  c_frame: cover property ($fell(host_oe));
endmodule // dcu_link_props

// file: tb/daisy_chain_uart_protocol_tb.sv
`timescale 1ns/100ps
module daisy_chain_uart_protocol_tb;
  import dcu_pkg::*;
  localparam int BDIV = 16;
  localparam int TMO = 20000;
  logic clk, rst, req_valid, chain_i, nv_valid, sel, stp;
  logic req_ready, rsp_valid, done, chain_o, chain_oe, nv_wr, reg_wr, srst, ac1, ac2;
  logic [2:0] pulses;
  logic [23:0] wr_seen;
  dcu_byte_type req_cmd, req_ptr, rsp_byte, reg_ptr, b;
  dcu_word_type req_data, reg_wdata, reg_rdata;
  dcu_addr_type my_addr, nv_addr, nv_seen;
  dcu_byte_type rsp_q [$];
  int fails = 0;
  int num_checks = 0;
  int n_wr = 0;
  int n_nv = 0;
  dcu_link_if link();
  wire probe = sel ? chain_o : link.line;
  assign reg_rdata = {8'hC3, reg_ptr ^ 8'h5A};
  dcu_host #(.BAUD_DIV(BDIV), .LISTEN_CYC(2000)) dcu_host_i (.CLK(clk), .RST(rst), .LINK(link.host),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_CMD(req_cmd), .REQ_PTR(req_ptr),
    .REQ_DATA(req_data), .RSP_VALID(rsp_valid), .RSP_BYTE(rsp_byte), .DONE(done));
  dcu_device #(.GAP_CYC(200), .TMO_CYC(TMO)) dcu_device_i (.CLK(clk), .RST(rst), .LINK(link.device),
    .CHAIN_I(chain_i), .CHAIN_O(chain_o), .CHAIN_OE(chain_oe), .NV_ADDR(nv_addr), .NV_VALID(nv_valid),
    .NV_WR(nv_wr), .MY_ADDR(my_addr), .REG_WR(reg_wr), .REG_PTR(reg_ptr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .SOFT_RESET(srst), .ALERT_CLEAR_1(ac1), .ALERT_CLEAR_2(ac2));
  dcu_link_props #(.BAUD_DIV(BDIV)) dcu_link_props_i (.CLK(clk), .RST(rst), .host_o(link.host_o),
    .host_oe(link.host_oe), .dev_o(link.dev_o), .dev_oe(link.dev_oe), .line(link.line),
    .CHAIN_I(chain_i), .CHAIN_O(chain_o), .CHAIN_OE(chain_oe));
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Collect answers and pulses on the user side
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) rsp_q.push_back(rsp_byte);
    if (reg_wr === 1'b1) wr_seen <= {reg_ptr, reg_wdata};
    if (reg_wr === 1'b1) n_wr++;
    if (nv_wr === 1'b1) nv_seen <= my_addr;
    if (nv_wr === 1'b1) n_nv++;
    pulses <= pulses | {srst, ac1, ac2};
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hand one request to the host and wait for its completion
  task automatic op(input dcu_byte_type c, input dcu_byte_type p, input dcu_word_type d);
    int k;
    k = 0;
    @(negedge clk);
    rsp_q.delete();
    pulses = 3'b000;
    req_cmd = c;
    req_ptr = p;
    req_data = d;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    while (done !== 1'b1 && k < 40000) begin
      @(negedge clk);
      k++;
    end
    check(k < 40000, 1);
    check(req_ready, 1'b1);
  endtask
  // Receive one word from the probed line, sampled mid-bit
  task automatic rx(output dcu_byte_type v, output logic s);
    v = 8'h00;
    while (probe !== 1'b0) @(negedge clk);
    repeat (BDIV / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BDIV) @(negedge clk);
      v[i] = probe;
    end
    repeat (BDIV) @(negedge clk);
    s = probe;
  endtask
  // Downstream sensor answering on the chain pin
  task automatic chain_tx(input dcu_byte_type v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      chain_i = f[i];
      repeat (BDIV) @(negedge clk);
    end
  endtask
  // Global write reaching address zero, with wire order checked
  task automatic t_write();
    int w;
    w = n_wr;
    sel = 1'b0;
    fork
      op(8'h01, 8'h03, 16'hA55A);
      begin
        rx(b, stp);
        check(b, 8'h55);
        check(stp, 1'b1);
        rx(b, stp);
        check(b, 8'h01);
      end
    join
    check(n_wr - w, 1);
    check(wr_seen, 24'h03A55A);
    check(rsp_q.size(), 0);
  endtask
  // Individual read answered low byte first
  task automatic t_read(input dcu_byte_type c, input dcu_byte_type p);
    int w;
    w = n_wr;
    op(c, p, 16'h0000);
    check(rsp_q.size(), 2);
    check(rsp_q[0], p ^ 8'h5A);
    check(rsp_q[1], 8'hC3);
    check(n_wr - w, 0);
  endtask
  // Each command raises only its own pulse; a reserved code nothing
  task automatic t_cmds();
    dcu_byte_type codes [4] = '{8'h5D, 8'hB5, 8'h75, 8'h0D};
    logic [2:0] exp [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
    int w;
    w = n_wr;
    for (int i = 0; i < 4; i++) begin
      op(codes[i], 8'h00, 16'h0000);
      check(pulses, exp[i]);
    end
    check(n_wr - w, 0);
  endtask
  // Address assignment: forwarded frames, then own frames down the chain
  task automatic t_init();
    dcu_byte_type fr [6] = '{8'h55, 8'h95, 8'h0D, 8'h55, 8'h95, 8'h15};
    sel = 1'b1;
    fork
      op(8'h95, 8'h00, 16'h000D);
      for (int i = 0; i < 6; i++) begin
        rx(b, stp);
        check(b, fr[i]);
      end
    join
    sel = 1'b0;
    check(rsp_q.size(), 1);
    check(rsp_q[0], 8'h0D);
    check(my_addr, 5'h01);
    check(n_nv, 1);
    check(nv_seen, 5'h01);
    repeat (TMO) @(negedge clk);
    check(chain_oe, 1'b1);
    check(link.dev_oe, 1'b0);
  endtask
  // Read addressed past this sensor, answered from downstream
  task automatic t_relay();
    int k;
    k = 0;
    fork
      op(8'h12, 8'h01, 16'h0000);
      begin
        while (chain_oe !== 1'b0 && k < 5000) begin
          @(negedge clk);
          k++;
        end
        chain_tx(8'h3C);
        chain_tx(8'hE1);
      end
    join
    check(rsp_q.size(), 2);
    check(rsp_q[0], 8'h3C);
    check(rsp_q[1], 8'hE1);
  endtask
  // Stored address comes back after a reset
  task automatic t_reload();
    @(negedge clk);
    nv_addr = nv_seen;
    nv_valid = 1'b1;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    check(my_addr, 5'h00);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    check(my_addr, 5'h01);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = 8'h00;
    req_ptr = 8'h00;
    req_data = 16'h0000;
    chain_i = 1'b1;
    nv_addr = 5'h00;
    nv_valid = 1'b0;
    sel = 1'b0;
    pulses = 3'b000;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    check(my_addr, 5'h00);
    repeat (20) @(negedge clk);
    check(link.dev_oe, 1'b0);
    t_write();
    t_read(8'h02, 8'h05);
    t_cmds();
    t_init();
    op(8'h57, 8'h00, 16'h0000);
    check(rsp_q.size(), 1);
    check(rsp_q[0], 8'h0F);
    t_read(8'h0A, 8'h07);
    t_relay();
    t_reload();
    t_read(8'h0A, 8'h21);
    summarize();
  end
  // Cut a hang short well past the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule // daisy_chain_uart_protocol_tb
